/* File: verilog/pdl_pkg.sv */
package pdl_pkg;
  localparam int NUM_PORTS = 9;
  localparam logic [15:0] ADDR_PORT1 = 16'hFF01;
  localparam logic [15:0] ADDR_PORT2 = 16'hFF02;
  localparam logic [15:0] ADDR_PORT3 = 16'hFF03;
  localparam logic [15:0] ADDR_PORT4 = 16'hFF04;
  localparam logic [15:0] ADDR_PORT10 = 16'hFF0A;
  localparam logic [15:0] ADDR_PORT11 = 16'hFF0B;
  localparam logic [15:0] ADDR_PORT12 = 16'hFF0C;
  localparam logic [15:0] ADDR_PORT14 = 16'hFF0E;
  localparam logic [15:0] ADDR_PORT15 = 16'hFF0F;
  // port index order used throughout
  localparam int IDX_PORT12 = 6;
  localparam int IDX_PORT14 = 7;
  localparam int IDX_PORT15 = 8;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  // implemented bit masks; other positions are fixed zero
  localparam logic [7:0] MASK_PORT1 = 8'h0C;
  localparam logic [7:0] MASK_PORT2 = 8'h3F;
  localparam logic [7:0] MASK_PORT3 = 8'h1E;
  localparam logic [7:0] MASK_PORT4 = 8'h01;
  localparam logic [7:0] MASK_PORT10 = 8'h03;
  localparam logic [7:0] MASK_PORT11 = 8'h0C;
  localparam logic [7:0] MASK_PORT12 = 8'h1F;
  localparam logic [7:0] MASK_PORT14 = 8'hFF;
  localparam logic [7:0] MASK_PORT15 = 8'hFF;
  // port 12 bits 1..4 are read-only pin levels
  localparam logic [7:0] RO_PORT12 = 8'h1E;
  // port 14/15 bits 7..4 are key scan bits
  localparam logic [7:0] KEYSCAN_MASK = 8'hF0;
endpackage

/* File: verilog/pdl_port_data.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - writes store in latch; latch drives output pins
// - input-mode read returns live pin level
// - output-mode read returns stored latch value
// - bit and byte accesses, read and write
// - reset clears every output latch to zero
// - port 12 bits 1-4 ignore writes
// - port 12 read-only latch bits cleared to zero by reset
// - clock-input pin of port 12 reads zero
// - port 14/15 upper nibble are key scan bits
// - data 1 means high, 0 means low
// - direction bit 0 output, 1 input
module pdl_port_data (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // processor access
  input wire logic [15:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic bit_access,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic hit,
  // per-pin direction from the mode registers
  input wire logic [71:0] pin_direction_bit,
  // port 12 pins in clock input mode
  input wire logic [7:0] clock_input_mode,
  // pins
  input wire logic [71:0] pin_in,
  output logic [71:0] pin_out,
  output logic [71:0] pin_oe,
  // key scan bits to the display driver
  output logic [3:0] segment_scan_a,
  output logic [3:0] segment_scan_b
);

  typedef struct packed {
    logic [71:0] latch;
    logic [7:0] rdata;
    logic hit;
  } pdl_state_t;

  pdl_state_t st;
  pdl_state_t next_st;

  function automatic int pdl_index(input logic [15:0] a);
    case (a)
      pdl_pkg::ADDR_PORT1: pdl_index = 0;
      pdl_pkg::ADDR_PORT2: pdl_index = 1;
      pdl_pkg::ADDR_PORT3: pdl_index = 2;
      pdl_pkg::ADDR_PORT4: pdl_index = 3;
      pdl_pkg::ADDR_PORT10: pdl_index = 4;
      pdl_pkg::ADDR_PORT11: pdl_index = 5;
      pdl_pkg::ADDR_PORT12: pdl_index = 6;
      pdl_pkg::ADDR_PORT14: pdl_index = 7;
      pdl_pkg::ADDR_PORT15: pdl_index = 8;
      default: pdl_index = -1;
    endcase
  endfunction

  function automatic logic [7:0] pdl_wmask(input int i);
    case (i)
      0: pdl_wmask = pdl_pkg::MASK_PORT1;
      1: pdl_wmask = pdl_pkg::MASK_PORT2;
      2: pdl_wmask = pdl_pkg::MASK_PORT3;
      3: pdl_wmask = pdl_pkg::MASK_PORT4;
      4: pdl_wmask = pdl_pkg::MASK_PORT10;
      5: pdl_wmask = pdl_pkg::MASK_PORT11;
      6: pdl_wmask = pdl_pkg::MASK_PORT12;
      7: pdl_wmask = pdl_pkg::MASK_PORT14;
      8: pdl_wmask = pdl_pkg::MASK_PORT15;
      default: pdl_wmask = 8'h00;
    endcase
  endfunction

  // read view of one port: pin in input mode, latch in output mode
  function automatic logic [7:0] pdl_view(input int i, input logic [71:0] lat);
    logic [7:0] v;
    v = 8'h00;
    for (int b = 0; b < 8; b++) begin
      v[b] = pin_direction_bit[i*8+b] ? pin_in[i*8+b] : lat[i*8+b];
    end
    if (i == pdl_pkg::IDX_PORT12) begin
      v = v & ~clock_input_mode;
    end
    pdl_view = v & pdl_wmask(i);
  endfunction

  int idx;
  logic [7:0] wmask;
  logic [7:0] bmask;
  logic [7:0] cur;
  logic [7:0] newv;

  always_comb begin
    next_st = st;
    idx = pdl_index(addr);
    wmask = 8'h00;
    bmask = 8'h00;
    cur = 8'h00;
    newv = 8'h00;
    next_st.hit = 1'b0;
    if (idx >= 0) begin
      wmask = pdl_wmask(idx);
      if (idx == pdl_pkg::IDX_PORT12) begin
        wmask = wmask & ~pdl_pkg::RO_PORT12;
      end
      bmask = bit_access ? (8'h01 << bit_sel) : 8'hFF;
      if (wr_en) begin
        cur = st.latch[idx*8 +: 8];
        newv = (cur & ~(wmask & bmask)) | (wdata & wmask & bmask);
        next_st.latch[idx*8 +: 8] = newv;
      end
      if (rd_en) begin
        next_st.rdata = pdl_view(idx, st.latch) & bmask;
        next_st.hit = 1'b1;
      end
    end else if (rd_en) begin
      next_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st.latch <= {pdl_pkg::NUM_PORTS{pdl_pkg::LATCH_RESET}};
      st.rdata <= 8'h00;
      st.hit <= 1'b0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // pins: latch drives pin when direction bit is 0, 1 is high
  assign pin_out = st.latch;
  assign pin_oe = ~pin_direction_bit;
  assign rdata = st.rdata;
  assign hit = st.hit;
  // key scan bits come from latches, not pins
  assign segment_scan_a = st.latch[pdl_pkg::IDX_PORT14*8+4 +: 4];
  assign segment_scan_b = st.latch[pdl_pkg::IDX_PORT15*8+4 +: 4];

  latch_write_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && wr_en && !bit_access && addr == pdl_pkg::ADDR_PORT2
    |=> pin_out[13:8] == $past(wdata[5:0]))
    else $error("port 2 latch not updated");
  reset_clear_a: assert property (@(posedge mclk)
    reset |=> pin_out == 72'h0)
    else $error("latches not cleared by reset");
  input_read_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && rd_en && !bit_access && addr == pdl_pkg::ADDR_PORT2 && pin_direction_bit[8]
    |=> rdata[0] == $past(pin_in[8]))
    else $error("input read not pin level");
  output_read_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && rd_en && !bit_access && addr == pdl_pkg::ADDR_PORT2 && !pin_direction_bit[8]
    |=> rdata[0] == $past(pin_out[8]))
    else $error("output read not latch");
  bit_write_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && wr_en && bit_access && bit_sel == 3'h0 && addr == pdl_pkg::ADDR_PORT2
    |=> pin_out[15:9] == $past(pin_out[15:9]))
    else $error("bit write disturbed other bits");
  ro_bits_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en |=> pin_out[52:49] == 4'h0)
    else $error("port 12 read-only bits written");
  clock_read_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && rd_en && addr == pdl_pkg::ADDR_PORT12 && clock_input_mode[1]
    |=> rdata[1] == 1'b0)
    else $error("clock input pin read non-zero");
  fixed_zero_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && rd_en && addr == pdl_pkg::ADDR_PORT1 |=> rdata[7:4] == 4'h0)
    else $error("fixed zero bit read one");
  oe_dir_a: assert property (@(posedge mclk) pin_oe[0] == !pin_direction_bit[0])
    else $error("output enable wrong");
  // unmapped addresses must never look like a port hit
  unmapped_read_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && rd_en && pdl_index(addr) < 0 |=> !hit && rdata == 8'h00)
    else $error("unmapped read returned data");
  mapped_hit_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && rd_en && addr == pdl_pkg::ADDR_PORT15 |=> hit)
    else $error("port read did not hit");
  rdata_hold_a: assert property (@(posedge mclk) disable iff (reset)
    !(clk_en && rd_en) |=> $stable(rdata))
    else $error("read data changed without a read");
  freeze_hold_a: assert property (@(posedge mclk) disable iff (reset)
    !clk_en |=> $stable(pin_out))
    else $error("latches moved while frozen");
  bit_read_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && rd_en && bit_access && bit_sel == 3'h2 |=> (rdata & 8'hFB) == 8'h00)
    else $error("bit read leaked other bits");
  ro_pin_read_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && rd_en && !bit_access && addr == pdl_pkg::ADDR_PORT12 && pin_direction_bit[49]
    && !clock_input_mode[1] |=> rdata[1] == $past(pin_in[49]))
    else $error("port 12 read-only bit not pin level");

  cov_byte_write: cover property (@(posedge mclk) clk_en && wr_en && !bit_access && hit == 1'b0);
  cov_bit_write: cover property (@(posedge mclk) clk_en && wr_en && bit_access);
  cov_input_read: cover property (@(posedge mclk) clk_en && rd_en && pin_direction_bit[8]);
  cov_unmapped_read: cover property (@(posedge mclk) clk_en && rd_en && pdl_index(addr) < 0);
  cov_frozen_write: cover property (@(posedge mclk) !clk_en && wr_en);

endmodule
`default_nettype wire

/* File: sim/pdl_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pdl_pin_model (
  // from the port block
  input wire logic [71:0] pin_out,
  input wire logic [71:0] pin_oe,
  // level forced by the outside world on undriven pins
  input wire logic [71:0] ext_level,
  // to the port block
  output logic [71:0] pin_in
);
  // a driven pin shows its latch level, an input pin shows the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

/* File: sim/port_data_latch_registers_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, a, b); end end
module port_data_latch_registers_bench;
  localparam logic [15:0] AD[10] = '{pdl_pkg::ADDR_PORT1, pdl_pkg::ADDR_PORT2,
    pdl_pkg::ADDR_PORT3, pdl_pkg::ADDR_PORT4, pdl_pkg::ADDR_PORT10, pdl_pkg::ADDR_PORT11,
    pdl_pkg::ADDR_PORT12, pdl_pkg::ADDR_PORT14, pdl_pkg::ADDR_PORT15, 16'hFF05};
  localparam logic [7:0] MK[9] = '{pdl_pkg::MASK_PORT1, pdl_pkg::MASK_PORT2,
    pdl_pkg::MASK_PORT3, pdl_pkg::MASK_PORT4, pdl_pkg::MASK_PORT10, pdl_pkg::MASK_PORT11,
    pdl_pkg::MASK_PORT12, pdl_pkg::MASK_PORT14, pdl_pkg::MASK_PORT15};
  logic mclk = 0, reset = 1, wr_en = 0, rd_en = 0, bit_access = 0, hit, pend = 0, ce = 1;
  logic [7:0] held;
  logic [15:0] addr = 0;
  logic [2:0] bit_sel = 0;
  logic [7:0] wdata = 0, rdata, cim = 0, lat[9];
  logic [71:0] dir = 0, ext = 0, pin_in, pin_out, pin_oe;
  logic [3:0] scan_a, scan_b;
  logic [8:0] expq[$];
  int mismatches = 0, samples_checked = 0, cyc = 0;
  always #20 mclk = ~mclk;
  pdl_port_data u_pdl_port_data (.mclk(mclk), .reset(reset), .clk_en(ce), .addr(addr),
    .wr_en(wr_en), .rd_en(rd_en), .bit_access(bit_access), .bit_sel(bit_sel),
    .wdata(wdata), .rdata(rdata), .hit(hit), .pin_direction_bit(dir),
    .clock_input_mode(cim), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .segment_scan_a(scan_a), .segment_scan_b(scan_b));
  pdl_pin_model u_pdl_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .pin_in(pin_in));
  function automatic logic [8:0] ex(int i, bit b, int s);
    logic [7:0] v;
    if (i > 8) return 9'h000;
    v = ((dir[i*8+:8] & ext[i*8+:8]) | (~dir[i*8+:8] & lat[i])) & MK[i];
    if (i == 6) v = v & ~cim;
    if (b) v = v & (8'h01 << s);
    return {1'b1, v};
  endfunction
  task automatic acc(int i, bit w, bit b, int s, logic [7:0] d);
    logic [7:0] wm;
    @(negedge mclk);
    addr = AD[i]; wr_en = w; rd_en = !w; bit_access = b; bit_sel = s[2:0]; wdata = d;
    if (w && i < 9) begin
      wm = MK[i] & ((i == 6) ? ~pdl_pkg::RO_PORT12 : 8'hFF);
      if (b) wm = wm & (8'h01 << s);
      lat[i] = (lat[i] & ~wm) | (d & wm);
    end
    if (!w) expq.push_back(ex(i, b, s));
  endtask
  task automatic do_reset();
    @(negedge mclk); reset = 1; wr_en = 0; rd_en = 0;
    repeat (6) @(negedge mclk);
    reset = 0;
    foreach (lat[k]) lat[k] = pdl_pkg::LATCH_RESET;
    for (int i = 0; i < 10; i++) acc(i, 0, 0, 0, 0);
  endtask
  task automatic final_report();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) pend <= rd_en && !reset && ce;
  // reads answer one edge late, so compare half a cycle after that edge
  always @(negedge mclk) if (pend) `CHK({hit, rdata}, expq.pop_front())
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin mismatches++; final_report(); end
  end
  initial begin
    void'($urandom(27));
    do_reset();
    for (int r = 0; r < 8; r++) begin
      @(negedge mclk);
      dir = (r == 0) ? 72'h0 : {$urandom, $urandom, $urandom};
      ext = {$urandom, $urandom, $urandom};
      cim = (r > 4) ? 8'h1E : 8'h00;
      for (int i = 0; i < 10; i++) acc(i, 1, 0, 0, $urandom);
      for (int i = 0; i < 10; i++) acc(i, 0, 0, 0, 0);
      for (int i = 0; i < 10; i++) acc(i, 1, 1, i % 8, $urandom);
      for (int i = 0; i < 10; i++) acc(i, 0, 1, (i + r) % 8, 0);
      @(negedge mclk); wr_en = 0; rd_en = 0;
      @(negedge mclk);
      for (int i = 0; i < 9; i++) begin
        `CHK(pin_out[i*8+:8] & MK[i], lat[i] & MK[i])
        `CHK(pin_oe[i*8+:8], ~dir[i*8+:8])
      end
      `CHK({scan_a, scan_b}, {lat[7][7:4], lat[8][7:4]})
      if (r == 3) do_reset();
    end
    // frozen clock enable: the write must not land
    held = lat[1];
    ce = 0;
    acc(1, 1, 0, 0, ~held);
    lat[1] = held;
    @(negedge mclk); wr_en = 0; ce = 1;
    @(negedge mclk);
    `CHK(pin_out[15:8] & MK[1], lat[1] & MK[1])
    repeat (3) @(negedge mclk);
    final_report();
  end
endmodule
`default_nettype wire
